// ==== logic/splc_pkg.sv ====
// Package for the stack pointer limit checker: register map, field layout,
// reset values, operation codes and state encodings.
// Assumes a 16-bit byte-addressed data space of two-byte words.
package splc_pkg;

  // Wishbone register byte offsets.
  localparam logic [3:0]  ADDR_STACK_PTR   = 4'h0;
  localparam logic [3:0]  ADDR_UPPER_LIMIT = 4'h4;
  localparam logic [3:0]  ADDR_STATUS      = 4'h8;

  // Status register field positions.
  localparam int          STAT_OVF_BIT     = 0;
  localparam int          STAT_UNF_BIT     = 1;

  // Fixed floor below which the stack may not go.
  localparam logic [15:0] STACK_FLOOR      = 16'h0800;
  // One word is two byte addresses.
  localparam logic [15:0] WORD_STEP        = 16'h0002;
  // Stack pointer value after reset.
  localparam logic [15:0] STACK_PTR_RESET  = 16'h0800;

  // Stack operations requested by the core.
  typedef enum logic [2:0] {
    SPLC_OP_NONE  = 3'h0,
    SPLC_OP_PUSH  = 3'h1,
    SPLC_OP_POP   = 3'h2,
    SPLC_OP_CALL  = 3'h3,
    SPLC_OP_EXCP  = 3'h4
  } splc_op_t;

  // Request from the core address generation logic.
  typedef struct packed {
    logic        valid;
    splc_op_t    op;
    logic [15:0] data;
    logic [6:0]  pcHigh;
    logic [7:0]  statusLowByte;
  } splc_req_t;

  // Bus answer state machine states, one-hot.
  typedef enum logic [1:0] {
    SPLC_BUS_IDLE = 2'b01,
    SPLC_BUS_ACK  = 2'b10
  } splc_bus_state_t;

endpackage

// ==== logic/splc_bound_cmp.sv ====
// Address comparator for the stack pointer limit checker.
// Compares one effective address against the upper limit and the floor.
// Assumes all three inputs are word aligned byte addresses.
`timescale 1ns/1ps
module splc_bound_cmp #(
  parameter int WIDTH = 16
) (
  // Operands
  input  wire logic [WIDTH-1:0] addr,
  input  wire logic [WIDTH-1:0] upperLimit,
  input  wire logic [WIDTH-1:0] floorAddr,
  // Results
  output logic                  aboveLimit,
  output logic                  belowFloor
);

  // Both comparisons are unsigned address compares.
  assign aboveLimit = addr > upperLimit;
  assign belowFloor = addr < floorAddr;

endmodule // splc_bound_cmp

// ==== logic/splc_checker.sv ====
// Stack pointer management with upper limit and floor checking.
// Assumes the core presents one stack request per cycle at most and
// that software reaches the registers over a classic Wishbone bus.
// Contract
// [R1] The stack pointer always holds the address of the first free word and the stack grows upward.
// [R2] A push writes at the stack pointer then increments it, and a pop decrements it first then reads.
// [R3] A call push zero-extends the program counter high part so the pushed top bit is clear.
// [R4] An exception push places the status low byte beside the program counter high part.
// [R5] The upper limit register sets the stack top and is not initialised by reset.
// [R6] Bit 0 of the upper limit and of the stack pointer always reads as zero; here the limit bit 0 is undefined until the first limit write.
// [R7] Every stack-pointer-based effective address is compared with the upper limit.
// [R8] A push made while the stack pointer equals the limit raises no trap.
// [R9] The next push, once the pointer exceeds the limit, raises a stack error trap.
// [R10] A stack address below 0x0800 raises a stack error underflow trap.
// [R11] Software should not follow a limit write directly by an indirect read through the stack pointer.
// [R12] Each push or pop moves the pointer by one word and the trap is a one-cycle request in the address cycle.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
module splc_checker (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Core stack request
  input  wire splc_pkg::splc_req_t stackReq,
  // Memory access toward data RAM
  output logic                     memValid,
  output logic                     memWrite,
  output logic      [15:0]         memAddr,
  output logic      [15:0]         memData,
  // Trap request toward exception logic
  output logic                     stackTrap
);

  // Register state.
  logic [15:0]                stackPtr;
  logic [15:0]                next_stackPtr;
  logic [15:0]                upperLimit;
  logic [15:0]                next_upperLimit;
  logic [1:0]                 errFlags;
  logic [1:0]                 next_errFlags;
  logic                       next_memValid;
  logic                       next_memWrite;
  logic [15:0]                next_memAddr;
  logic [15:0]                next_memData;
  logic                       next_stackTrap;
  splc_pkg::splc_bus_state_t  busState;
  splc_pkg::splc_bus_state_t  next_busState;
  logic [31:0]                next_wbDat;
  logic                       next_wbAck;

  // Decoded request and effective address.
  logic        isPush;
  logic        isPop;
  logic [15:0] effAddr;
  logic        aboveLimit;
  logic        belowFloor;
  logic        busReq;
  logic        busWrite;

  assign isPush  = stackReq.valid && (stackReq.op == splc_pkg::SPLC_OP_PUSH
                || stackReq.op == splc_pkg::SPLC_OP_CALL || stackReq.op == splc_pkg::SPLC_OP_EXCP);
  assign isPop   = stackReq.valid && stackReq.op == splc_pkg::SPLC_OP_POP;
  // Push uses the pointer as is; pop pre-decrements. [R2]
  assign effAddr = isPop ? stackPtr - splc_pkg::WORD_STEP : stackPtr;
  assign busReq  = wb_cyc_i && wb_stb_i && busState == splc_pkg::SPLC_BUS_IDLE;
  // A write lands at the edge where the master samples ack high, not at the request edge.
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && busState == splc_pkg::SPLC_BUS_ACK
                 && wb_sel_i[0] && wb_sel_i[1];

  // Limit and floor comparison of every stack-pointer effective address. [R7]
  splc_bound_cmp #(
    .WIDTH      (16)
  ) u_cmp (
    .addr       (effAddr),
    .upperLimit (upperLimit),
    .floorAddr  (splc_pkg::STACK_FLOOR),
    .aboveLimit (aboveLimit),
    .belowFloor (belowFloor)
  );

  // Next stack pointer, memory access and trap.
  always_comb begin
    next_stackPtr  = stackPtr;
    next_memValid  = 1'b0;
    next_memWrite  = 1'b0;
    next_memAddr   = memAddr;
    next_memData   = memData;
    next_stackTrap = 1'b0;
    next_errFlags  = errFlags;
    if (isPush || isPop) begin
      next_memValid = 1'b1;
      next_memWrite = isPush;
      next_memAddr  = effAddr;
      // Equal to the limit passes; only above it traps. [R8] [R9]
      // Any address below the floor traps as underflow. [R10]
      next_stackTrap = aboveLimit || belowFloor; // [R12]
      if (isPush) begin
        // Post-increment by one word keeps the pointer on the first free word. [R1] [R2] [R12]
        next_stackPtr = stackPtr + splc_pkg::WORD_STEP;
      end else begin
        next_stackPtr = effAddr; // [R2]
      end
      case (stackReq.op)
        // Call: top bit forced clear, high part zero-extended. [R3]
        splc_pkg::SPLC_OP_CALL: next_memData = {9'h000, stackReq.pcHigh};
        // Exception: status low byte beside the program counter high part. [R4]
        splc_pkg::SPLC_OP_EXCP: next_memData = {1'b0, stackReq.statusLowByte, stackReq.pcHigh};
        default:                next_memData = stackReq.data;
      endcase
    end
    // Software write to the pointer; bit 0 forced to zero. [R6]
    if (busWrite && wb_adr_i == splc_pkg::ADDR_STACK_PTR) begin
      next_stackPtr = {wb_dat_i[15:1], 1'b0};
    end
    // Sticky error flags: a new trap wins over a software clear.
    if (busWrite && wb_adr_i == splc_pkg::ADDR_STATUS) begin
      next_errFlags = errFlags & ~wb_dat_i[1:0];
    end
    if (isPush || isPop) begin
      next_errFlags[splc_pkg::STAT_OVF_BIT] = next_errFlags[splc_pkg::STAT_OVF_BIT] | aboveLimit;
      next_errFlags[splc_pkg::STAT_UNF_BIT] = next_errFlags[splc_pkg::STAT_UNF_BIT] | belowFloor;
    end
  end

  // Upper limit next value; bit 0 forced clear on every write. [R6]
  always_comb begin
    next_upperLimit = upperLimit;
    if (busWrite && wb_adr_i == splc_pkg::ADDR_UPPER_LIMIT) begin
      next_upperLimit = {wb_dat_i[15:1], 1'b0}; // [R6]
    end
  end

  // Wishbone answer: ack one cycle after the request, then drop.
  always_comb begin
    next_busState = splc_pkg::SPLC_BUS_IDLE;
    next_wbAck    = 1'b0;
    next_wbDat    = 32'h0000_0000;
    case (busState)
      splc_pkg::SPLC_BUS_IDLE: begin
        if (busReq) begin
          next_busState = splc_pkg::SPLC_BUS_ACK;
          next_wbAck    = 1'b1;
          case (wb_adr_i)
            splc_pkg::ADDR_STACK_PTR:   next_wbDat = {16'h0000, stackPtr};
            splc_pkg::ADDR_UPPER_LIMIT: next_wbDat = {16'h0000, upperLimit};
            splc_pkg::ADDR_STATUS:      next_wbDat = {30'h0000_0000, errFlags};
            default:                    next_wbDat = 32'h0000_0000;
          endcase
        end
      end
      splc_pkg::SPLC_BUS_ACK:  next_busState = splc_pkg::SPLC_BUS_IDLE;
      default:                 next_busState = splc_pkg::SPLC_BUS_IDLE;
    endcase
  end

  // Registers with reset; the upper limit is deliberately left out of reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stackPtr  <= splc_pkg::STACK_PTR_RESET;
      errFlags  <= 2'h0;
      memValid  <= 1'b0;
      memWrite  <= 1'b0;
      memAddr   <= 16'h0000;
      memData   <= 16'h0000;
      stackTrap <= 1'b0;
      busState  <= splc_pkg::SPLC_BUS_IDLE;
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
    end else begin
      stackPtr  <= next_stackPtr;
      errFlags  <= next_errFlags;
      memValid  <= next_memValid;
      memWrite  <= next_memWrite;
      memAddr   <= next_memAddr;
      memData   <= next_memData;
      stackTrap <= next_stackTrap;
      busState  <= next_busState;
      wb_ack_o  <= next_wbAck;
      wb_dat_o  <= next_wbDat;
    end
  end

  // The limit keeps whatever it holds across reset. [R5]
  always_ff @(posedge clk_sys) begin
    upperLimit <= next_upperLimit; // [R5]
  end

  // Push-at-limit sequence: a push at the limit is clean, the next one traps.
  sequence pushAtLimit_s;
    isPush && stackPtr == upperLimit && stackPtr >= splc_pkg::STACK_FLOOR && !busWrite;
  endsequence

  sequence nextPush_s;
    isPush && !busWrite;
  endsequence

  limit_equal_ok_a: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
    pushAtLimit_s |=> !stackTrap)
    else $error("Push at the limit raised a trap.");

  limit_exceed_trap_a: assert property (@(posedge clk_sys) disable iff (rst) // [R9]
    pushAtLimit_s ##1 nextPush_s |=> stackTrap)
    else $error("Push beyond the limit did not trap.");

  floor_underflow_a: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    (isPush || isPop) && effAddr < 16'h0800 |=> stackTrap && errFlags[1])
    else $error("Underflow below the floor did not trap.");

  push_step_a: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    isPush && !busWrite |=> stackPtr == $past(stackPtr) + 16'h0002 && memAddr == $past(stackPtr))
    else $error("Push did not write then increment by one word.");

  pop_step_a: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
    isPop && !busWrite |=> stackPtr == $past(stackPtr) - 16'h0002 && memAddr == stackPtr && !memWrite)
    else $error("Pop did not pre-decrement by one word.");

  call_msb_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
    stackReq.valid && stackReq.op == splc_pkg::SPLC_OP_CALL |=> memData[15:7] == 9'h000)
    else $error("Call push top bits not clear.");

  excp_status_a: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
    stackReq.valid && stackReq.op == splc_pkg::SPLC_OP_EXCP
    |=> memData[14:7] == $past(stackReq.statusLowByte) && !memData[15])
    else $error("Exception push lacks the status low byte.");

  align_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    !stackPtr[0])
    else $error("Stack pointer not word aligned.");

  // The limit holds no defined value until its first write, so it is checked after each write.
  limit_align_a: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    busWrite && wb_adr_i == splc_pkg::ADDR_UPPER_LIMIT
    |=> !upperLimit[0] && upperLimit[15:1] == $past(wb_dat_i[15:1]))
    else $error("Upper limit write not word aligned.");

  trap_pulse_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    stackTrap |-> $past(isPush || isPop))
    else $error("Trap without a stack address cycle.");

  bus_ack_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus ack held longer than one cycle.");

  // Bus interface checks.
  bus_ack_timing_a: assert property (@(posedge clk_sys) disable iff (rst)
    busReq |=> wb_ack_o)
    else $error("Bus request not acknowledged in the next cycle.");

  bus_data_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("Read data not zero outside ack.");

  ptr_write_a: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
    busWrite && wb_adr_i == splc_pkg::ADDR_STACK_PTR
    |=> stackPtr == {$past(wb_dat_i[15:1]), 1'b0})
    else $error("Pointer write did not land word aligned.");

  lane_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    wb_cyc_i && wb_stb_i && wb_we_i && busState == splc_pkg::SPLC_BUS_ACK && wb_sel_i[1:0] != 2'b11
    && !isPush && !isPop |=> $stable(stackPtr))
    else $error("Write without both low lanes changed the pointer.");

  status_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    busWrite && wb_adr_i == splc_pkg::ADDR_STATUS && !isPush && !isPop
    |=> (errFlags & $past(wb_dat_i[1:0])) == 2'h0)
    else $error("Status write did not clear the flags.");

  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    errFlags[splc_pkg::STAT_OVF_BIT] && !(busWrite && wb_adr_i == splc_pkg::ADDR_STATUS)
    |=> errFlags[splc_pkg::STAT_OVF_BIT])
    else $error("Overflow flag dropped without a clear.");

  // Stack access checks.
  sequence popAbove_s;
    isPop && effAddr > upperLimit;
  endsequence

  pop_limit_trap_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    popAbove_s |=> stackTrap && errFlags[splc_pkg::STAT_OVF_BIT])
    else $error("Pop above the limit did not trap.");

  in_range_quiet_a: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
    (isPush || isPop) && effAddr <= upperLimit && effAddr >= splc_pkg::STACK_FLOOR |=> !stackTrap)
    else $error("Trap raised for an address inside the stack.");

  access_pulse_a: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
    (isPush || isPop) |=> memValid && memWrite == $past(isPush))
    else $error("Stack access not issued with the right direction.");

  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (rst) // [R12]
    !isPush && !isPop |=> !memValid && !stackTrap)
    else $error("Access or trap without a stack request.");

  first_free_a: assert property (@(posedge clk_sys) disable iff (rst) // [R1]
    isPush && !busWrite |=> stackPtr == memAddr + 16'h0002)
    else $error("Pointer does not address the first free word after a push.");

  call_pc_low_a: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
    stackReq.valid && stackReq.op == splc_pkg::SPLC_OP_CALL |=> memData[6:0] == $past(stackReq.pcHigh))
    else $error("Call push lost the program counter high part.");

  excp_pc_low_a: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
    stackReq.valid && stackReq.op == splc_pkg::SPLC_OP_EXCP |=> memData[6:0] == $past(stackReq.pcHigh))
    else $error("Exception push lost the program counter high part.");

endmodule // splc_checker

// ==== test/splc_core_model.sv ====
// Model of the core address generation logic that issues stack requests.
// Assumes the checker samples stackReq on every rising clk_sys edge.
`timescale 1ns/1ps
module splc_core_model (
  // Clock
  input  wire logic         clk_sys,
  // Stack request toward the checker
  output splc_pkg::splc_req_t stackReq
);
  // Idle until the bench asks for a request.
  initial stackReq = '0;

  // Issues one request for one cycle, then scrambles the idle payload.
  task automatic issue(input splc_pkg::splc_op_t op, input logic [15:0] d,
                       input logic [6:0] pch, input logic [7:0] slb);
    @(posedge clk_sys);
    stackReq <= '{1'b1, op, d, pch, slb};
    @(posedge clk_sys);
    stackReq <= '{1'b0, splc_pkg::SPLC_OP_NONE, ~d, ~pch, ~slb};
    #1;
  endtask
endmodule // splc_core_model

// ==== test/splc_checker_tb_top.sv ====
// Self-checking bench for the stack pointer limit checker.
// Assumes a registered Wishbone ack and stack outputs that stand one cycle.
`timescale 1ns/1ps
module splc_checker_tb_top;
  logic                clk_sys, rst, cyc, stb, we;
  logic [3:0]          adr, sel;
  logic [31:0]         datI, datO, rd;
  logic                ack, memValid, memWrite, stackTrap;
  logic [15:0]         memAddr, memData;
  splc_pkg::splc_req_t stackReq;
  int                  err_count, checks, cycles;

  splc_checker dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
    .wb_ack_o(ack), .stackReq(stackReq), .memValid(memValid), .memWrite(memWrite),
    .memAddr(memAddr), .memData(memData), .stackTrap(stackTrap));
  splc_core_model core (.clk_sys(clk_sys), .stackReq(stackReq));

  // Clock at 125 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; ack and read data are taken at the rising edge that samples ack high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    {cyc, stb, we, adr, sel, datI} <= {2'b11, w, a, s, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    rd = datO;
    {cyc, stb, we, datI} <= {3'b000, ~d};
  endtask

  // Issues a stack request and checks the memory access it makes.
  task automatic op(input splc_pkg::splc_op_t o, input logic [15:0] d, input logic [7:0] slb,
                    input logic [15:0] ea, input logic wr, input logic [15:0] ed, input logic tr);
    core.issue(o, d, 7'h7F, slb);
    chk(memValid, 1'b1);
    chk(memWrite, wr);
    chk(memAddr, ea);
    if (wr) chk(memData, ed);
    chk(stackTrap, tr);
  endtask

  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end

  // Main sequence.
  initial begin
    {rst, cyc, stb, we, adr, sel, datI, err_count, checks, cycles} = '0;
    rst = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    wb(0, splc_pkg::ADDR_STACK_PTR, 4'hF, 0);
    chk(rd, 32'h0800);
    wb(0, splc_pkg::ADDR_STATUS, 4'hF, 0);
    chk(rd, 32'h0);
    wb(1, splc_pkg::ADDR_UPPER_LIMIT, 4'hF, 32'hFFFF0A03);
    wb(0, splc_pkg::ADDR_UPPER_LIMIT, 4'hF, 0);
    chk(rd, 32'h0A02);
    wb(1, splc_pkg::ADDR_STACK_PTR, 4'hF, 32'h0A01);
    wb(0, splc_pkg::ADDR_STACK_PTR, 4'hF, 0);
    chk(rd, 32'h0A00);
    op(splc_pkg::SPLC_OP_PUSH, 16'h1234, 0, 16'h0A00, 1, 16'h1234, 0);
    op(splc_pkg::SPLC_OP_PUSH, 16'h5678, 0, 16'h0A02, 1, 16'h5678, 0);
    op(splc_pkg::SPLC_OP_PUSH, 16'h9ABC, 0, 16'h0A04, 1, 16'h9ABC, 1);
    wb(0, splc_pkg::ADDR_STACK_PTR, 4'hF, 0);
    chk(rd, 32'h0A06);
    wb(0, splc_pkg::ADDR_STATUS, 4'hF, 0);
    chk(rd, 32'h1);
    wb(1, splc_pkg::ADDR_STATUS, 4'hF, 32'h3);
    wb(0, splc_pkg::ADDR_STATUS, 4'hF, 0);
    chk(rd, 32'h0);
    // This pop address still lies above the limit, so it traps and sets overflow again.
    op(splc_pkg::SPLC_OP_POP, 16'h0, 0, 16'h0A04, 0, 16'h0, 1);
    op(splc_pkg::SPLC_OP_POP, 16'h0, 0, 16'h0A02, 0, 16'h0, 0);
    op(splc_pkg::SPLC_OP_CALL, 16'hFFFF, 0, 16'h0A02, 1, 16'h007F, 0);
    op(splc_pkg::SPLC_OP_POP, 16'h0, 0, 16'h0A02, 0, 16'h0, 0);
    op(splc_pkg::SPLC_OP_EXCP, 16'hFFFF, 8'hA5, 16'h0A02, 1, {1'b0, 8'hA5, 7'h7F}, 0);
    wb(1, splc_pkg::ADDR_STACK_PTR, 4'hF, 32'h0800);
    op(splc_pkg::SPLC_OP_POP, 16'h0, 0, 16'h07FE, 0, 16'h0, 1);
    // Both flags stand: overflow from the earlier pop, underflow from this one.
    wb(0, splc_pkg::ADDR_STATUS, 4'hF, 0);
    chk(rd, 32'h3);
    wb(1, splc_pkg::ADDR_STACK_PTR, 4'h0, 32'h0C00);
    wb(0, splc_pkg::ADDR_STACK_PTR, 4'hF, 0);
    chk(rd, 32'h07FE);
    wb(1, 4'hC, 4'hF, 32'h1234);
    wb(0, 4'hC, 4'hF, 0);
    chk(rd, 32'h0);
    // Reset in mid-run: pointer and flags go back to their reset values, the limit keeps its value.
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    wb(0, splc_pkg::ADDR_STACK_PTR, 4'hF, 0);
    chk(rd, 32'h0800);
    wb(0, splc_pkg::ADDR_STATUS, 4'hF, 0);
    chk(rd, 32'h0);
    wb(0, splc_pkg::ADDR_UPPER_LIMIT, 4'hF, 0);
    chk(rd, 32'h0A02);
    final_report();
  end
endmodule // splc_checker_tb_top
